/* File: hw/ifm_mode_ctrl.sv */
// in-system flash mode control: registers, decode, flash strobes
// assumes synchronous register port, reads answered one cycle later
`timescale 1ns/1ps
module ifm_mode_ctrl #(
   parameter int MAIN_BYTES = ifm_pkg::IFM_MAIN_BYTES,
   parameter int LOADER_BYTES = ifm_pkg::IFM_LOADER_BYTES
) (
   input wire logic ref_clk, // 40 MHz clock
   input wire logic nrst, // sync reset, active low
   input wire logic [7:0] reg_addr, // register offset
   input wire logic [7:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [7:0] reg_rdata, // read data, cycle after strobe
   output logic flash_chip_enable, // flash chip enable line
   output logic flash_output_enable, // flash output enable line
   output logic [3:0] flash_ctrl_code, // flash control code
   output logic flash_bank_select // 1 loader array, 0 main array
);
   logic [7:0] mode_r;
   logic [7:0] addr_low_r;
   logic [7:0] addr_high_r;
   logic [7:0] data_buf_r;
   logic done_r;
   logic rd_pend_r;
   ifm_pkg::ifm_op_e op_r;
   ifm_pkg::ifm_op_e op_nxt;
   ifm_pkg::ifm_req_s req;
   logic [7:0] arr_rdata;
   logic mode_wr;

   // ****************************************
   // operation decode
   // ****************************************
   function automatic ifm_pkg::ifm_op_e decode_op(input logic [7:0] m);
      logic oe;
      logic ce;
      logic [3:0] code;
      oe = m[ifm_pkg::IFM_OE_BIT];
      ce = m[ifm_pkg::IFM_CE_BIT];
      code = m[ifm_pkg::IFM_CODE_LSB +: 4];
      if (oe && !ce && code == ifm_pkg::IFM_CODE_ERASE) return ifm_pkg::IFM_OP_ERASE;
      if (oe && !ce && code == ifm_pkg::IFM_CODE_PROGRAM) return ifm_pkg::IFM_OP_PROGRAM;
      if (!oe && !ce && code == ifm_pkg::IFM_CODE_READ) return ifm_pkg::IFM_OP_READ;
      return ifm_pkg::IFM_OP_NONE;
   endfunction

   assign mode_wr = reg_wr && reg_addr == ifm_pkg::IFM_MODE_CTRL_OFS;
   // at most one operation launched per write of the mode register, none if the mode does not decode
   assign op_nxt = mode_wr ? decode_op(reg_wdata & ifm_pkg::IFM_MODE_WMASK) : ifm_pkg::IFM_OP_NONE;

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (!nrst) mode_r <= ifm_pkg::IFM_MODE_RESET;
      else if (mode_wr) mode_r <= reg_wdata & ifm_pkg::IFM_MODE_WMASK;
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         addr_low_r <= ifm_pkg::IFM_BYTE_RESET;
         addr_high_r <= ifm_pkg::IFM_BYTE_RESET;
      end else if (reg_wr) begin
         if (reg_addr == ifm_pkg::IFM_ADDR_LOW_OFS) addr_low_r <= reg_wdata;
         if (reg_addr == ifm_pkg::IFM_ADDR_HIGH_OFS) addr_high_r <= reg_wdata;
      end
   end

   // data buffer: read result wins over a software write in same cycle
   always_ff @(posedge ref_clk) begin
      if (!nrst) data_buf_r <= ifm_pkg::IFM_BYTE_RESET;
      else if (rd_pend_r) data_buf_r <= arr_rdata;
      else if (reg_wr && reg_addr == ifm_pkg::IFM_DATA_BUF_OFS) data_buf_r <= reg_wdata;
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         op_r <= ifm_pkg::IFM_OP_NONE;
         rd_pend_r <= 1'b0;
      end else begin
         op_r <= op_nxt;
         rd_pend_r <= op_r == ifm_pkg::IFM_OP_READ;
      end
   end

   // done flag: set on completion, cleared by a new mode write; set wins
   always_ff @(posedge ref_clk) begin
      if (!nrst) done_r <= 1'b0;
      else if (rd_pend_r || op_r == ifm_pkg::IFM_OP_ERASE || op_r == ifm_pkg::IFM_OP_PROGRAM) done_r <= 1'b1;
      else if (mode_wr) done_r <= 1'b0;
   end

   // ****************************************
   // flash control lines
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         flash_chip_enable <= 1'b0;
         flash_output_enable <= 1'b0;
         flash_ctrl_code <= 4'h0;
         flash_bank_select <= 1'b0;
      end else if (mode_wr) begin
         flash_chip_enable <= reg_wdata[ifm_pkg::IFM_CE_BIT];
         flash_output_enable <= reg_wdata[ifm_pkg::IFM_OE_BIT];
         flash_ctrl_code <= reg_wdata[ifm_pkg::IFM_CODE_LSB +: 4];
         flash_bank_select <= reg_wdata[ifm_pkg::IFM_BANK_BIT];
      end
   end

   // ****************************************
   // array request
   // ****************************************
   // one driver for the whole request word
   assign req = '{
      bank: mode_r[ifm_pkg::IFM_BANK_BIT],
      addr: {addr_high_r, addr_low_r},
      wdata: data_buf_r
   };

   ifm_flash_array #(
      .MAIN_BYTES(MAIN_BYTES),
      .LOADER_BYTES(LOADER_BYTES)
   ) u_array (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .op(op_r),
      .req(req),
      .rdata(arr_rdata)
   );

   // ****************************************
   // read port
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (!nrst) reg_rdata <= 8'h00;
      else if (reg_rd) begin
         unique case (reg_addr)
            ifm_pkg::IFM_ADDR_LOW_OFS: reg_rdata <= addr_low_r;
            ifm_pkg::IFM_ADDR_HIGH_OFS: reg_rdata <= addr_high_r;
            ifm_pkg::IFM_DATA_BUF_OFS: reg_rdata <= data_buf_r;
            ifm_pkg::IFM_MODE_CTRL_OFS: reg_rdata <= mode_r;
            ifm_pkg::IFM_STATUS_OFS: reg_rdata <= {6'h00, done_r, op_r != ifm_pkg::IFM_OP_NONE || rd_pend_r};
            default: reg_rdata <= 8'h00;
         endcase
      end else reg_rdata <= 8'h00;
   end
endmodule

/* File: include/ifm_pkg.sv */
// constants and carrier types for the in-system flash mode control block
// assumes an 8-bit register port at special-register offsets, one clock domain
package ifm_pkg;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] IFM_ADDR_LOW_OFS = 8'hAC;
   localparam logic [7:0] IFM_ADDR_HIGH_OFS = 8'hAD;
   localparam logic [7:0] IFM_DATA_BUF_OFS = 8'hAE;
   localparam logic [7:0] IFM_MODE_CTRL_OFS = 8'hAF;
   localparam logic [7:0] IFM_STATUS_OFS = 8'hB7;
   // ****************************************
   // mode control fields and reset values
   // ****************************************
   localparam int IFM_BANK_BIT = 6;
   localparam int IFM_OE_BIT = 5;
   localparam int IFM_CE_BIT = 4;
   localparam int IFM_CODE_LSB = 0;
   localparam logic [7:0] IFM_MODE_RESET = 8'h00;
   localparam logic [7:0] IFM_BYTE_RESET = 8'h00;
   localparam logic [7:0] IFM_MODE_WMASK = 8'h7F;
   localparam logic [3:0] IFM_CODE_ERASE = 4'h2;
   localparam logic [3:0] IFM_CODE_PROGRAM = 4'h1;
   localparam logic [3:0] IFM_CODE_READ = 4'h0;
   // ****************************************
   // array sizes and status bit positions
   // ****************************************
   localparam int IFM_MAIN_BYTES = 16384;
   localparam int IFM_LOADER_BYTES = 4096;
   localparam int IFM_STAT_BUSY_BIT = 0;
   localparam int IFM_STAT_DONE_BIT = 1;

   typedef enum logic [3:0] {
      IFM_OP_NONE = 4'b0001,
      IFM_OP_ERASE = 4'b0010,
      IFM_OP_PROGRAM = 4'b0100,
      IFM_OP_READ = 4'b1000
   } ifm_op_e;

   // request to the flash array
   typedef struct packed {
      logic bank;
      logic [15:0] addr;
      logic [7:0] wdata;
   } ifm_req_s;
endpackage

/* File: hw/ifm_flash_array.sv */
// flash array model: main and loader banks held in flip-flops
// assumes one operation per cycle, requests from the mode control block
`timescale 1ns/1ps
module ifm_flash_array #(
   parameter int MAIN_BYTES = ifm_pkg::IFM_MAIN_BYTES,
   parameter int LOADER_BYTES = ifm_pkg::IFM_LOADER_BYTES
) (
   input wire logic ref_clk, // clock
   input wire logic nrst, // sync reset, active low
   input wire ifm_pkg::ifm_op_e op, // operation this cycle
   input wire ifm_pkg::ifm_req_s req, // bank, address, data
   output logic [7:0] rdata // read byte, one cycle later
);
   logic [7:0] main_mem [MAIN_BYTES];
   logic [7:0] ldr_mem [LOADER_BYTES];
   // small arrays index the low address bits only
   localparam int MAIN_AW = $clog2(MAIN_BYTES);
   localparam int LDR_AW = $clog2(LOADER_BYTES);
   logic [MAIN_AW-1:0] main_idx;
   logic [LDR_AW-1:0] ldr_idx;

   assign main_idx = req.addr[MAIN_AW-1:0];
   assign ldr_idx = req.addr[LDR_AW-1:0];

   // ****************************************
   // storage; erase sets all bytes of the selected bank to FF
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (op == ifm_pkg::IFM_OP_ERASE) begin
         if (req.bank) begin
            for (int i = 0; i < LOADER_BYTES; i++) ldr_mem[i] <= 8'hFF;
         end else begin
            for (int i = 0; i < MAIN_BYTES; i++) main_mem[i] <= 8'hFF;
         end
      end else if (op == ifm_pkg::IFM_OP_PROGRAM) begin
         if (req.bank) ldr_mem[ldr_idx] <= req.wdata;
         else main_mem[main_idx] <= req.wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) rdata <= ifm_pkg::IFM_BYTE_RESET;
      else if (op == ifm_pkg::IFM_OP_READ) rdata <= req.bank ? ldr_mem[ldr_idx] : main_mem[main_idx];
   end
endmodule

/* File: bench/ifm_mode_ctrl_properties.sv */
// port checker for the flash mode control block
// assumes the ports of ifm_mode_ctrl, bound from the testbench
`timescale 1ns/1ps
module ifm_mode_ctrl_properties #(
   parameter int MAIN_BYTES = 64,
   parameter int LOADER_BYTES = 64
) (
   input wire logic ref_clk, // clock
   input wire logic nrst, // sync reset
   input wire logic [7:0] reg_addr, // offset
   input wire logic [7:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   input wire logic [7:0] reg_rdata, // read data
   input wire logic flash_chip_enable, // chip enable
   input wire logic flash_output_enable, // output enable
   input wire logic [3:0] flash_ctrl_code, // control code
   input wire logic flash_bank_select // bank
);
   // ****************************************
   // port relations
   // ****************************************
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   logic mw;
   assign mw = reg_wr && reg_addr == ifm_pkg::IFM_MODE_CTRL_OFS;
   AST_BANK: assert property (mw |=> flash_bank_select == $past(reg_wdata[6])) else $error("bank wrong");
   AST_CE: assert property (mw |=> flash_chip_enable == $past(reg_wdata[4])) else $error("ce wrong");
   AST_OE: assert property (mw |=> flash_output_enable == $past(reg_wdata[5])) else $error("oe wrong");
   AST_CODE: assert property (mw |=> flash_ctrl_code == $past(reg_wdata[3:0])) else $error("code wrong");
   AST_HOLD: assert property (!mw |=> $stable({flash_bank_select, flash_output_enable, flash_chip_enable,
      flash_ctrl_code})) else $error("lines moved");
   AST_RDBK: assert property (reg_rd && reg_addr == ifm_pkg::IFM_MODE_CTRL_OFS |=> reg_rdata == {1'b0,
      flash_bank_select, flash_output_enable, flash_chip_enable, flash_ctrl_code}) else $error("mode readback");
   AST_ADDR: assert property (reg_wr && reg_addr == ifm_pkg::IFM_ADDR_LOW_OFS ##1 reg_rd && reg_addr ==
      ifm_pkg::IFM_ADDR_LOW_OFS |=> reg_rdata == $past(reg_wdata, 2)) else $error("address readback");
   AST_ZERO: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray read data");
endmodule

/* File: bench/ifm_flash_watch.sv */
// far-side model: decodes the flash lines into the operation they request
// assumes the lines are stable between mode writes
`timescale 1ns/1ps
module ifm_flash_watch (
   input wire logic flash_chip_enable, // chip enable
   input wire logic flash_output_enable, // output enable
   input wire logic [3:0] flash_ctrl_code, // control code
   output ifm_pkg::ifm_op_e op_seen // decoded operation
);
   // ****************************************
   // decode
   // ****************************************
   always_comb begin
      op_seen = ifm_pkg::IFM_OP_NONE;
      if (!flash_chip_enable && flash_output_enable && flash_ctrl_code == 4'h2) op_seen = ifm_pkg::IFM_OP_ERASE;
      if (!flash_chip_enable && flash_output_enable && flash_ctrl_code == 4'h1) op_seen = ifm_pkg::IFM_OP_PROGRAM;
      if (!flash_chip_enable && !flash_output_enable && flash_ctrl_code == 4'h0) op_seen = ifm_pkg::IFM_OP_READ;
   end
endmodule

/* File: bench/testbench.sv */
// self-checking bench for ifm_mode_ctrl with small arrays
// assumes the checker and far-side model files are compiled first
`timescale 1ns/1ps
module testbench;
   // ****************************************
   // stimulus and checks
   // ****************************************
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, got;
   logic reg_wr = 1'b0, reg_rd = 1'b0, ce, oe, bank;
   logic [3:0] code;
   ifm_pkg::ifm_op_e op;
   int err_count = 0, n_tests = 0;
   always #12.5 ref_clk = ~ref_clk;
   ifm_mode_ctrl #(.MAIN_BYTES(64), .LOADER_BYTES(64)) dut_u (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_chip_enable(ce),
      .flash_output_enable(oe), .flash_ctrl_code(code), .flash_bank_select(bank));
   ifm_flash_watch far_u (.flash_chip_enable(ce), .flash_output_enable(oe), .flash_ctrl_code(code), .op_seen(op));
   task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a);
      acc(1'b0, 1'b1, a, 8'h00);
      #1 got = reg_rdata;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic run(input logic [7:0] m, input ifm_pkg::ifm_op_e e);
      acc(1'b1, 1'b0, ifm_pkg::IFM_MODE_CTRL_OFS, m);
      acc(1'b0, 1'b0, 8'h00, 8'h00);
      chk({4'h0, op}, {4'h0, e});
      acc(1'b0, 1'b0, 8'h00, 8'h00);
   endtask
   task automatic t_regs;
      rd(8'hAF);
      chk(got, 8'h00);
      rd(8'h10);
      chk(got, 8'h00);
      acc(1'b1, 1'b0, 8'hAF, 8'hFF);
      rd(8'hAF);
      chk(got, 8'h7F);
      chk({bank, oe, ce, 1'b0, code}, 8'hEF);
      acc(1'b1, 1'b0, 8'hAD, 8'h12);
      rd(8'hAD);
      chk(got, 8'h12);
      acc(1'b1, 1'b0, 8'hAC, 8'h25);
      rd(8'hAC);
      chk(got, 8'h25);
   endtask
   task automatic t_flash;
      run(8'h22, ifm_pkg::IFM_OP_ERASE);
      run(8'h62, ifm_pkg::IFM_OP_ERASE);
      acc(1'b1, 1'b0, 8'hAE, 8'hA5);
      run(8'h21, ifm_pkg::IFM_OP_PROGRAM);
      acc(1'b1, 1'b0, 8'hAE, 8'h3C);
      run(8'h61, ifm_pkg::IFM_OP_PROGRAM);
      run(8'h00, ifm_pkg::IFM_OP_READ);
      rd(8'hAE);
      chk(got, 8'hA5);
      run(8'h40, ifm_pkg::IFM_OP_READ);
      rd(8'hAE);
      chk(got, 8'h3C);
      acc(1'b1, 1'b0, 8'hAC, 8'h26);
      run(8'h00, ifm_pkg::IFM_OP_READ);
      rd(8'hAE);
      chk(got, 8'hFF);
   endtask
   task automatic t_noop;
      acc(1'b1, 1'b0, 8'hAC, 8'h25);
      acc(1'b1, 1'b0, 8'hAE, 8'h77);
      run(8'h23, ifm_pkg::IFM_OP_NONE);
      run(8'h31, ifm_pkg::IFM_OP_NONE);
      run(8'h00, ifm_pkg::IFM_OP_READ);
      rd(8'hAE);
      chk(got, 8'hA5);
   endtask
   task automatic t_status;
      acc(1'b1, 1'b0, ifm_pkg::IFM_MODE_CTRL_OFS, 8'h00);
      rd(ifm_pkg::IFM_STATUS_OFS);
      chk(got, 8'h01);
      rd(ifm_pkg::IFM_STATUS_OFS);
      chk(got, 8'h01);
      rd(ifm_pkg::IFM_STATUS_OFS);
      chk(got, 8'h02);
      acc(1'b1, 1'b0, ifm_pkg::IFM_MODE_CTRL_OFS, 8'h23);
      acc(1'b0, 1'b0, 8'h00, 8'h00);
      rd(ifm_pkg::IFM_STATUS_OFS);
      chk(got, 8'h00);
   endtask
   task automatic summarize;
      $display("comparisons=%0d mismatches=%0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      t_regs;
      t_flash;
      t_noop;
      t_status;
      summarize;
   end
endmodule
bind ifm_mode_ctrl ifm_mode_ctrl_properties #(.MAIN_BYTES(MAIN_BYTES), .LOADER_BYTES(LOADER_BYTES)) chk_u (
   .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .flash_chip_enable(flash_chip_enable), .flash_output_enable(flash_output_enable),
   .flash_ctrl_code(flash_ctrl_code), .flash_bank_select(flash_bank_select));
